// ---- design/tmr_timer16_defines.vh ----
// Register offsets, field positions, reset values and divider counts of the 16-bit timer
`ifndef TMR_TIMER16_DEFINES_VH
`define TMR_TIMER16_DEFINES_VH

// ==========================================================
// Register offsets
`define TMR_A_CR2 4'h1
`define TMR_A_CR1 4'h2
`define TMR_A_SR 4'h3
`define TMR_A_IC1H 4'h4
`define TMR_A_IC1L 4'h5
`define TMR_A_OC1H 4'h6
`define TMR_A_OC1L 4'h7
`define TMR_A_CNTH 4'h8
`define TMR_A_CNTL 4'h9
`define TMR_A_ACNTH 4'ha
`define TMR_A_ACNTL 4'hb
`define TMR_A_IC2H 4'hc
`define TMR_A_IC2L 4'hd
`define TMR_A_OC2H 4'he
`define TMR_A_OC2L 4'hf

// ==========================================================
// Control register one fields
`define TMR_CR1_CAPTURE_IRQ_ENABLE 7
`define TMR_CR1_COMPARE_IRQ_ENABLE 6
`define TMR_CR1_OVERFLOW_IRQ_ENABLE 5
`define TMR_CR1_FORCE2 4
`define TMR_CR1_FORCE1 3
`define TMR_CR1_LVL2 2
`define TMR_CR1_EDGE1 1
`define TMR_CR1_LVL1 0

// ==========================================================
// Control register two fields
`define TMR_CR2_PIN1_EN 7
`define TMR_CR2_PIN2_EN 6
`define TMR_CR2_ONE_PULSE 5
`define TMR_CR2_PWM 4
`define TMR_CR2_CC_HI 3
`define TMR_CR2_CC_LO 2
`define TMR_CR2_EDGE2 1
`define TMR_CR2_EXT_EDGE 0

// ==========================================================
// Flag register fields
`define TMR_SR_TIMD 2

// ==========================================================
// Reset and load values
`define TMR_CR_RST 8'h00
`define TMR_CNT_RST 16'hfffc
`define TMR_CNT_TOP 16'hffff
`define TMR_IC1_PULSE 16'hfffd
`define TMR_OC_RST 16'h8000
`define TMR_CAP_RST 16'h0000

// ==========================================================
// Clock select codes and divider terminal counts
`define TMR_CC_DIV4 2'h0
`define TMR_CC_DIV2 2'h1
`define TMR_CC_DIV8 2'h2
`define TMR_CC_EXT 2'h3
`define TMR_DIV4_MAX 3'h3
`define TMR_DIV2_MAX 3'h1
`define TMR_DIV8_MAX 3'h7

`endif

// ---- design/tmr_timer16.v ----
// Sixteen-bit timer with two captures, two compares, one-pulse and PWM modes
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "tmr_timer16_defines.vh"

// ==========================================================

module tmr_timer16 (
    input wire I_MCLK,
    input wire I_RST_N,
    input wire [3:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [7:0] O_RDATA,
    input wire I_CAP1,
    input wire I_CAP2,
    input wire I_EXTCLK,
    input wire I_HALT,
    input wire I_WAIT,
    input wire I_IMASK,
    output reg O_CMP1,
    output reg O_CMP1_OE,
    output reg O_CMP2,
    output reg O_CMP2_OE,
    output reg O_IRQ,
    output reg O_WAKE
);

    // ==========================================================
    // Pin synchronisers and edge detection
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    reg [2:0] prev_q;
    wire [2:0] rise = sync2_q & ~prev_q;
    wire [2:0] fall = ~sync2_q & prev_q;

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= {I_EXTCLK, I_CAP2, I_CAP1};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // ==========================================================
    // Software registers
    reg [7:0] cr1_q;
    reg [7:0] cr2_q;
    reg timd_q;
    reg [15:0] oc1_q;
    reg [15:0] oc2_q;
    reg [15:0] oc1_act_q;
    reg [15:0] oc2_act_q;
    reg inh1_q;
    reg inh2_q;
    reg [15:0] cnt_q;
    reg [15:0] ic1_q;
    reg [15:0] ic2_q;
    reg [2:0] psc_q;
    reg halt_q;
    reg arm1_q;
    reg arm2_q;
    reg lvl1_q;
    reg lvl2_q;
    reg [4:0] flag_q;
    reg [4:0] clr_arm_q;

    wire pwm = cr2_q[`TMR_CR2_PWM];
    wire one_pulse_enable = cr2_q[`TMR_CR2_ONE_PULSE] & ~pwm;
    wire [1:0] cc = cr2_q[`TMR_CR2_CC_HI:`TMR_CR2_CC_LO];
    wire cap1_edge = cr1_q[`TMR_CR1_EDGE1] ? rise[0] : fall[0];
    wire cap2_edge = cr2_q[`TMR_CR2_EDGE2] ? rise[1] : fall[1];
    wire ext_edge = cr2_q[`TMR_CR2_EXT_EDGE] ? rise[2] : fall[2];
    wire wr_cr1 = I_WR & (I_ADDR == `TMR_A_CR1);
    wire acc = I_WR | I_RD;

    // ==========================================================
    // Prescaler; halt and the disable bit both stop it
    wire run = ~I_HALT & ~timd_q;
    reg [2:0] div_max;
    always @* begin
        case (cc)
            `TMR_CC_DIV2: div_max = `TMR_DIV2_MAX;
            `TMR_CC_DIV8: div_max = `TMR_DIV8_MAX;
            default: div_max = `TMR_DIV4_MAX;
        endcase
    end
    // Reloads leave the prescaler phase alone, so a one-pulse start may lag a tick
    wire tick = run & ((cc == `TMR_CC_EXT) ? ext_edge : (psc_q == div_max));

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            psc_q <= 3'h0;
        end else if (run && cc != `TMR_CC_EXT) begin
            psc_q <= (psc_q == div_max) ? 3'h0 : psc_q + 3'h1;
        end
    end

    // ==========================================================
    // Counter, matches and overflow
    wire [15:0] cnt_inc = cnt_q + 16'h0001;
    wire wr_cnt = I_WR & ((I_ADDR == `TMR_A_CNTL) | (I_ADDR == `TMR_A_ACNTL));
    wire halt_exit = halt_q & ~I_HALT;
    wire opm_trig = one_pulse_enable & cap1_edge & ~I_HALT;
    reg [15:0] cnt_d;
    reg m1;
    reg m2;
    reg ovf;

    always @* begin
        cnt_d = cnt_q;
        m1 = 1'b0;
        m2 = 1'b0;
        ovf = 1'b0;
        // Reloads win over the tick, so no match or overflow fires on that cycle
        if (wr_cnt) begin
            cnt_d = `TMR_CNT_RST;
        end else if (opm_trig) begin
            cnt_d = `TMR_CNT_RST;
        end else if (tick) begin
            m1 = ~inh1_q & (cnt_inc == oc1_act_q);
            m2 = ~inh2_q & (cnt_inc == oc2_act_q);
            if (pwm && m2) begin
                cnt_d = `TMR_CNT_RST;
            end else begin
                cnt_d = cnt_inc;
                ovf = (cnt_q == `TMR_CNT_TOP);
            end
        end
    end

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cnt_q <= `TMR_CNT_RST;
            halt_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            halt_q <= I_HALT;
        end
    end

    // ==========================================================
    // Captures; edges seen in halt are held until halt ends
    // At halt exit the counter has not moved yet, so the held count is stored
    wire cap1_evt = ~pwm & ((cap1_edge & ~I_HALT) | (halt_exit & arm1_q));
    wire cap2_evt = (cap2_edge & ~I_HALT) | (halt_exit & arm2_q);

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            arm1_q <= 1'b0;
            arm2_q <= 1'b0;
            ic1_q <= `TMR_CAP_RST;
            ic2_q <= `TMR_CAP_RST;
        end else begin
            if (halt_exit) begin
                arm1_q <= 1'b0;
                arm2_q <= 1'b0;
            end else if (I_HALT) begin
                arm1_q <= arm1_q | (cap1_edge & ~pwm);
                arm2_q <= arm2_q | cap2_edge;
            end
            if (cap1_evt) begin
                ic1_q <= one_pulse_enable ? `TMR_IC1_PULSE : cnt_q;
            end
            if (cap2_evt) begin
                ic2_q <= cnt_q;
            end
        end
    end

    // ==========================================================
    // Control, compare values and compare inhibit
    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cr1_q <= `TMR_CR_RST;
            cr2_q <= `TMR_CR_RST;
            timd_q <= 1'b0;
            oc1_q <= `TMR_OC_RST;
            oc2_q <= `TMR_OC_RST;
            oc1_act_q <= `TMR_OC_RST;
            oc2_act_q <= `TMR_OC_RST;
            inh1_q <= 1'b0;
            inh2_q <= 1'b0;
        end else begin
            if (wr_cr1) begin
                cr1_q <= I_WDATA;
            end
            if (I_WR && I_ADDR == `TMR_A_CR2) begin
                cr2_q <= I_WDATA;
            end
            if (I_WR && I_ADDR == `TMR_A_SR) begin
                timd_q <= I_WDATA[`TMR_SR_TIMD];
            end
            if (I_WR && I_ADDR == `TMR_A_OC1H) begin
                oc1_q[15:8] <= I_WDATA;
                inh1_q <= 1'b1;
            end
            if (I_WR && I_ADDR == `TMR_A_OC1L) begin
                oc1_q[7:0] <= I_WDATA;
                inh1_q <= 1'b0;
            end
            if (I_WR && I_ADDR == `TMR_A_OC2H) begin
                oc2_q[15:8] <= I_WDATA;
                inh2_q <= 1'b1;
            end
            if (I_WR && I_ADDR == `TMR_A_OC2L) begin
                oc2_q[7:0] <= I_WDATA;
                inh2_q <= 1'b0;
            end
            // Buffered copies avoid spikes on the PWM pin mid-period
            if (!pwm || m2) begin
                oc1_act_q <= oc1_q;
                oc2_act_q <= oc2_q;
            end
        end
    end

    // ==========================================================
    // Flags: order is capture1, compare1, overflow, capture2, compare2
    wire [4:0] flag_set;
    wire [4:0] flag_clr;
    assign flag_set[4] = cap1_evt | (pwm & m2);
    assign flag_set[3] = m1 & ~pwm & ~one_pulse_enable;
    assign flag_set[2] = ovf;
    assign flag_set[1] = cap2_evt;
    assign flag_set[0] = m2 & ~pwm;
    assign flag_clr[4] = acc & (I_ADDR == `TMR_A_IC1L);
    assign flag_clr[3] = acc & (I_ADDR == `TMR_A_OC1L);
    assign flag_clr[2] = acc & (I_ADDR == `TMR_A_CNTL);
    assign flag_clr[1] = acc & (I_ADDR == `TMR_A_IC2L);
    assign flag_clr[0] = acc & (I_ADDR == `TMR_A_OC2L);
    wire sr_rd = I_RD & (I_ADDR == `TMR_A_SR);

    // A flag register read re-arms the clear from the flags standing at that moment
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag
            wire do_clr = flag_clr[gi] & clr_arm_q[gi];
            always @(posedge I_MCLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    flag_q[gi] <= 1'b0;
                    clr_arm_q[gi] <= 1'b0;
                end else begin
                    // A new event in the clearing cycle survives
                    flag_q[gi] <= flag_set[gi] | (flag_q[gi] & ~do_clr);
                    if (sr_rd) begin
                        clr_arm_q[gi] <= flag_q[gi];
                    end else if (do_clr) begin
                        clr_arm_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Compare pin levels
    wire force1 = wr_cr1 & I_WDATA[`TMR_CR1_FORCE1] & ~pwm & ~one_pulse_enable;
    wire force2 = wr_cr1 & I_WDATA[`TMR_CR1_FORCE2] & ~pwm & ~one_pulse_enable;

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            lvl1_q <= 1'b0;
            lvl2_q <= 1'b0;
        end else begin
            if (pwm || one_pulse_enable) begin
                if ((pwm && m2) || opm_trig) begin
                    lvl1_q <= cr1_q[`TMR_CR1_LVL2];
                end else if (m1) begin
                    lvl1_q <= cr1_q[`TMR_CR1_LVL1];
                end
            end else if (force1) begin
                lvl1_q <= I_WDATA[`TMR_CR1_LVL1];
            end else if (m1) begin
                lvl1_q <= cr1_q[`TMR_CR1_LVL1];
            end
            if (force2) begin
                lvl2_q <= I_WDATA[`TMR_CR1_LVL2];
            end else if (m2 && !pwm && !one_pulse_enable) begin
                lvl2_q <= cr1_q[`TMR_CR1_LVL2];
            end
        end
    end

    // ==========================================================
    // Interrupt request, wake and pins
    wire req = (cr1_q[`TMR_CR1_CAPTURE_IRQ_ENABLE] & (flag_q[4] | flag_q[1]))
        | (cr1_q[`TMR_CR1_COMPARE_IRQ_ENABLE] & (flag_q[3] | flag_q[0]))
        | (cr1_q[`TMR_CR1_OVERFLOW_IRQ_ENABLE] & flag_q[2]);

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_IRQ <= 1'b0;
            O_WAKE <= 1'b0;
            O_CMP1 <= 1'b0;
            O_CMP2 <= 1'b0;
            O_CMP1_OE <= 1'b0;
            O_CMP2_OE <= 1'b0;
        end else begin
            O_IRQ <= req & ~I_IMASK;
            // Halt is never ended from here, only wait
            O_WAKE <= req & ~I_IMASK & I_WAIT & ~I_HALT;
            O_CMP1 <= lvl1_q;
            O_CMP2 <= lvl2_q;
            O_CMP1_OE <= cr2_q[`TMR_CR2_PIN1_EN] & ~timd_q;
            O_CMP2_OE <= cr2_q[`TMR_CR2_PIN2_EN] & ~timd_q;
        end
    end

    // ==========================================================
    // Read port, data one cycle after the strobe
    // Counter halves are not latched; a carry may fall between two byte reads
    reg [7:0] rd_d;
    always @* begin
        case (I_ADDR)
            `TMR_A_CR2: rd_d = cr2_q;
            `TMR_A_CR1: rd_d = cr1_q;
            `TMR_A_SR: rd_d = {flag_q, timd_q, 2'b00};
            `TMR_A_IC1H: rd_d = ic1_q[15:8];
            `TMR_A_IC1L: rd_d = ic1_q[7:0];
            `TMR_A_OC1H: rd_d = oc1_q[15:8];
            `TMR_A_OC1L: rd_d = oc1_q[7:0];
            `TMR_A_CNTH: rd_d = cnt_q[15:8];
            `TMR_A_CNTL: rd_d = cnt_q[7:0];
            `TMR_A_ACNTH: rd_d = cnt_q[15:8];
            `TMR_A_ACNTL: rd_d = cnt_q[7:0];
            `TMR_A_IC2H: rd_d = ic2_q[15:8];
            `TMR_A_IC2L: rd_d = ic2_q[7:0];
            `TMR_A_OC2H: rd_d = oc2_q[15:8];
            `TMR_A_OC2L: rd_d = oc2_q[7:0];
            default: rd_d = 8'h00;
        endcase
    end

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= I_RD ? rd_d : 8'h00;
        end
    end

endmodule

// ---- verification/tmr_timer16_monitor.sv ----
// Port-level assertions for the 16-bit timer
`timescale 1ns/1ps
`include "tmr_timer16_defines.vh"

module tmr_timer16_monitor (
    input wire I_MCLK,
    input wire I_RST_N,
    input wire [3:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_HALT,
    input wire I_WAIT,
    input wire I_IMASK,
    input wire O_CMP1,
    input wire O_CMP1_OE,
    input wire O_CMP2,
    input wire O_CMP2_OE,
    input wire O_IRQ,
    input wire O_WAKE
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    // ====
    // Shadow control registers, rebuilt from bus writes
    reg [7:0] cr1_q;
    reg [7:0] cr2_q;
    wire plain = !cr2_q[`TMR_CR2_ONE_PULSE] && !cr2_q[`TMR_CR2_PWM];
    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cr1_q <= `TMR_CR_RST;
            cr2_q <= `TMR_CR_RST;
        end else if (I_WR && I_ADDR == `TMR_A_CR1) begin
            cr1_q <= I_WDATA;
        end else if (I_WR && I_ADDR == `TMR_A_CR2) begin
            cr2_q <= I_WDATA;
        end
    end

    // ====
    // Forced levels: write, internal update, registered pin
    sequence s_force1;
        I_WR && I_ADDR == `TMR_A_CR1 && I_WDATA[`TMR_CR1_FORCE1]
            && cr2_q[`TMR_CR2_PIN1_EN] && plain;
    endsequence
    sequence s_force2;
        I_WR && I_ADDR == `TMR_A_CR1 && I_WDATA[`TMR_CR1_FORCE2]
            && cr2_q[`TMR_CR2_PIN2_EN] && plain;
    endsequence
    chk_force_one: assert property (
        s_force1 |-> ##2 O_CMP1_OE && O_CMP1 == $past(I_WDATA[0], 2))
        else $error("first pin force level wrong");
    chk_force_two: assert property (
        s_force2 |-> ##2 O_CMP2_OE && O_CMP2 == $past(I_WDATA[2], 2))
        else $error("second pin force level wrong");

    // ====
    // Interrupt request and wake
    property p_irq_off;
        cr1_q[7:5] == 3'h0 && $past(cr1_q[7:5]) == 3'h0 |-> !O_IRQ;
    endproperty
    chk_irq_off: assert property (p_irq_off)
        else $error("request raised with every enable clear");
    chk_irq_mask: assert property ($past(I_IMASK) |-> !O_IRQ)
        else $error("request raised while masked");
    chk_wake_halt: assert property ($past(I_HALT) |-> !O_WAKE)
        else $error("timer woke the core from halt");
    chk_wake_mask: assert property ($past(I_IMASK) |-> !O_WAKE)
        else $error("wake while masked");
    chk_wake_wait: assert property (!$past(I_WAIT) |-> !O_WAKE)
        else $error("wake outside wait");

    // ====
    // Pin routing follows the enables
    chk_pin1_route: assert property (!$past(cr2_q[7]) |-> !O_CMP1_OE)
        else $error("first pin routed while disabled");
    chk_pin2_route: assert property (!$past(cr2_q[6]) |-> !O_CMP2_OE)
        else $error("second pin routed while disabled");
endmodule

// ---- verification/tmr_pin_src.sv ----
// Signal sources on the timer's capture and clock pins
`timescale 1ns/1ps

module tmr_pin_src (
    input wire i_clk,
    output logic o_cap1,
    output logic o_cap2,
    output logic o_extclk
);
    // Idle high; the external clock stands still as nothing here uses it
    initial begin
        o_cap1 = 1'b1;
        o_cap2 = 1'b1;
        o_extclk = 1'b0;
    end

    task drive(input logic c1, input logic c2);
        begin
            @(posedge i_clk);
            o_cap1 <= c1;
            o_cap2 <= c2;
        end
    endtask
endmodule

// ---- verification/tmr_timer16_test.sv ----
// Self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`include "tmr_timer16_defines.vh"

module tmr_timer16_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic halt = 1'b0;
    logic wt = 1'b0;
    logic imask = 1'b0;
    logic [7:0] rdata;
    logic cap1, cap2, extclk, cmp1, cmp1_oe, cmp2, cmp2_oe, irq, wake;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] d, h, l;
    // Rows: write flag, index, write data, expected read back
    logic [20:0] rows [0:12] = '{
        {1'b0, `TMR_A_CR2, 8'h00, 8'h00}, {1'b0, `TMR_A_CR1, 8'h00, 8'h00},
        {1'b0, `TMR_A_OC1H, 8'h00, 8'h80}, {1'b0, `TMR_A_OC1L, 8'h00, 8'h00},
        {1'b0, `TMR_A_OC2H, 8'h00, 8'h80}, {1'b0, `TMR_A_OC2L, 8'h00, 8'h00},
        {1'b0, 4'h0, 8'h00, 8'h00}, {1'b1, 4'h0, 8'h5a, 8'h00},
        {1'b1, `TMR_A_IC1H, 8'ha5, 8'h00}, {1'b1, `TMR_A_OC1H, 8'h12, 8'h12},
        {1'b1, `TMR_A_OC1L, 8'h34, 8'h34}, {1'b1, `TMR_A_CR2, 8'h04, 8'h04},
        {1'b1, `TMR_A_CR1, 8'ha6, 8'ha6}};

    always #5 clk = ~clk;

    tmr_timer16 i_tmr_timer16 (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
        .I_RD(rd_s), .O_RDATA(rdata), .I_CAP1(cap1), .I_CAP2(cap2), .I_EXTCLK(extclk),
        .I_HALT(halt), .I_WAIT(wt), .I_IMASK(imask), .O_CMP1(cmp1), .O_CMP1_OE(cmp1_oe),
        .O_CMP2(cmp2), .O_CMP2_OE(cmp2_oe), .O_IRQ(irq), .O_WAKE(wake)
    );
    tmr_pin_src i_tmr_pin_src (.i_clk(clk), .o_cap1(cap1), .o_cap2(cap2), .o_extclk(extclk));

    // ====
    // Bus, compare and wait helpers
    task chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            checked++;
            if (got !== exp) begin
                n_mismatch++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task test_done;
        begin
            $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] v);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= v;
            wr_s <= 1'b1;
            @(posedge clk);
            wr_s <= 1'b0;
        end
    endtask

    task rd(input logic [3:0] a, output logic [7:0] q);
        begin
            @(posedge clk);
            addr <= a;
            rd_s <= 1'b1;
            @(posedge clk);
            rd_s <= 1'b0;
            #1;
            q = rdata;
        end
    endtask

    // Counts cycles until the chosen output shows lvl; a hang ends the run
    task wait_for(input logic pin1, input logic lvl, output int n);
        logic s;
        begin
            n = 0;
            s = ~lvl;
            while (s !== lvl) begin
                @(posedge clk);
                #1;
                s = pin1 ? cmp1 : irq;
                n++;
                if (n > 300) begin
                    n_mismatch++;
                    test_done;
                end
            end
        end
    endtask

    // Period start 0xfffc, first compare 0x0004, second 0x0010, two cycles a tick
    task pwm_check;
        int n;
        int hi;
        int lo;
        begin
            wait_for(1'b1, 1'b0, n);
            wait_for(1'b1, 1'b1, n);
            wait_for(1'b1, 1'b0, hi);
            wait_for(1'b1, 1'b1, lo);
            chk(hi[7:0], 8'h10);
            chk(lo[7:0], 8'h18);
        end
    endtask

    // ====
    // Main sequence
    initial begin
        int i;
        int v;
        int e;
        int n;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 13; i++) begin
            if (rows[i][20]) begin
                wr(rows[i][19:16], rows[i][15:8]);
            end
            rd(rows[i][19:16], d);
            chk(d, rows[i][7:0]);
        end
        wr(`TMR_A_CR2, 8'hc0);
        for (v = 0; v < 4; v++) begin
            wr(`TMR_A_CR1, 8'h18 | {5'h00, v[1], 1'b0, v[0]});
            repeat (2) @(posedge clk);
            #1;
            chk({4'h0, cmp1_oe, cmp2_oe, cmp2, cmp1}, {6'h03, v[1:0]});
        end
        for (e = 0; e < 2; e++) begin
            i_tmr_pin_src.drive(e[0], 1'b1);
            wr(`TMR_A_CR1, {6'h00, e[0], 1'b0});
            repeat (6) @(posedge clk);
            rd(`TMR_A_SR, d);
            rd(`TMR_A_IC1L, d);
            i_tmr_pin_src.drive(!e[0], 1'b1);
            repeat (6) @(posedge clk);
            rd(`TMR_A_SR, d);
            chk(d & 8'h80, 8'h00);
            i_tmr_pin_src.drive(e[0], 1'b1);
            repeat (6) @(posedge clk);
            rd(`TMR_A_SR, d);
            chk(d & 8'h80, 8'h80);
        end
        wr(`TMR_A_CR2, 8'h04);
        wr(`TMR_A_CR1, 8'h20);
        wt <= 1'b1;
        wr(`TMR_A_CNTL, 8'h00);
        wait_for(1'b0, 1'b1, n);
        @(posedge clk);
        #1;
        chk({7'h00, wake}, 8'h01);
        @(posedge clk);
        imask <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
        @(posedge clk);
        imask <= 1'b0;
        rd(`TMR_A_SR, d);
        chk(d & 8'h20, 8'h20);
        rd(`TMR_A_CNTL, d);
        rd(`TMR_A_SR, d);
        chk(d & 8'h20, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
        @(posedge clk);
        halt <= 1'b1;
        rd(`TMR_A_CNTH, h);
        rd(`TMR_A_CNTL, l);
        i_tmr_pin_src.drive(1'b1, 1'b0);
        repeat (20) @(posedge clk);
        rd(`TMR_A_CNTL, d);
        chk(d, l);
        @(posedge clk);
        halt <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`TMR_A_SR, d);
        chk(d & 8'h10, 8'h10);
        rd(`TMR_A_IC2H, d);
        chk(d, h);
        rd(`TMR_A_IC2L, d);
        chk(d, l);
        wr(`TMR_A_OC2H, 8'h00);
        wr(`TMR_A_OC2L, 8'h10);
        wr(`TMR_A_OC1H, 8'h00);
        wr(`TMR_A_OC1L, 8'h04);
        wr(`TMR_A_CR1, 8'h84);
        wr(`TMR_A_CR2, 8'hb4);
        // Restart the count so the first period match is not a full wrap away
        wr(`TMR_A_CNTL, 8'h00);
        wait_for(1'b1, 1'b1, n);
        rd(`TMR_A_SR, d);
        rd(`TMR_A_IC1L, d);
        rd(`TMR_A_OC1L, d);
        rd(`TMR_A_OC2L, d);
        pwm_check;
        rd(`TMR_A_SR, d);
        chk(d & 8'hc8, 8'h80);
        chk({7'h00, irq}, 8'h01);
        rd(`TMR_A_IC1L, l);
        i_tmr_pin_src.drive(1'b0, 1'b1);
        i_tmr_pin_src.drive(1'b0, 1'b0);
        repeat (6) @(posedge clk);
        rd(`TMR_A_IC1L, d);
        chk(d, l);
        rd(`TMR_A_SR, d);
        chk(d & 8'h10, 8'h10);
        wr(`TMR_A_OC1H, 8'h00);
        repeat (50) @(posedge clk);
        v = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            v = v + (cmp1 === 1'b0);
        end
        chk(v[7:0], 8'h00);
        wr(`TMR_A_OC1L, 8'h04);
        pwm_check;
        // One-pulse: after a reload the first compare match parks the pin low, then a falling edge fires
        wr(`TMR_A_CR2, 8'ha4);
        wr(`TMR_A_CNTL, 8'h00);
        wait_for(1'b1, 1'b0, n);
        i_tmr_pin_src.drive(1'b1, 1'b0);
        i_tmr_pin_src.drive(1'b0, 1'b0);
        wait_for(1'b1, 1'b1, n);
        wait_for(1'b1, 1'b0, n);
        // Free-running prescaler puts the first tick one or two cycles out
        chk({7'h00, n == 15 || n == 16}, 8'h01);
        rd(`TMR_A_IC1L, d);
        chk(d, 8'hfd);
        wr(`TMR_A_CR1, 8'h81);
        wr(`TMR_A_CR2, 8'h84);
        wr(`TMR_A_CNTL, 8'h00);
        repeat (30) @(posedge clk);
        #1;
        chk({7'h00, cmp1}, 8'h01);
        // Reset while halted: counting restarts from the reset value
        @(posedge clk);
        halt <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        halt <= 1'b0;
        rd(`TMR_A_CNTH, h);
        chk(h, 8'hff);
        rd(`TMR_A_CNTL, l);
        chk(l, 8'hfc);
        test_done;
    end
endmodule

bind tmr_timer16 tmr_timer16_monitor i_tmr_timer16_monitor (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_HALT(I_HALT), .I_WAIT(I_WAIT), .I_IMASK(I_IMASK), .O_CMP1(O_CMP1),
    .O_CMP1_OE(O_CMP1_OE), .O_CMP2(O_CMP2), .O_CMP2_OE(O_CMP2_OE), .O_IRQ(O_IRQ),
    .O_WAKE(O_WAKE)
);
